// >>> inc/mtb_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------------
// constants and types shared by the pwm time base
// ----------------------------------------------------------------------------
package mtb_pkg;

  // apb byte offsets, one aligned word per register
  localparam int unsigned  ADDR_W       = 8;
  localparam logic [7:0]   OFS_CTRL     = 8'h00;  // time_base_control
  localparam logic [7:0]   OFS_COUNT    = 8'h04;  // time_base_count
  localparam logic [7:0]   OFS_PERIOD   = 8'h08;  // period compare
  localparam logic [7:0]   OFS_KEY      = 8'h0c;  // unlock_key_reg
  localparam logic [7:0]   OFS_FLT_A    = 8'h10;  // fault_a_control
  localparam logic [7:0]   OFS_FLT_B    = 8'h14;  // fault_b_control
  localparam logic [7:0]   OFS_OEN      = 8'h18;  // output_enable_control
  localparam logic [7:0]   OFS_INT_STAT = 8'h1c;  // sticky events, read clears
  localparam logic [7:0]   OFS_INT_MASK = 8'h20;  // interrupt mask

  // unlock keys, written back to back to the key register
  localparam logic [15:0]  KEY_FIRST    = 16'habcd;
  localparam logic [15:0]  KEY_SECOND   = 16'h4321;

  // control register layout, msb first
  typedef struct packed {
    logic       time_base_on;          // counter enable
    logic       rsv14;                 // reads zero
    logic       halt_in_idle;          // stop while cpu idles
    logic [4:0] rsv12_8;               // reads zero
    logic [3:0] output_postscale_sel;  // events per output event, minus one
    logic [1:0] input_prescale_sel;    // input clock divider
    logic [1:0] count_mode_sel;        // counting mode
  } mtb_ctrl_s;

  localparam logic [15:0]  CTRL_WMASK   = 16'ha0ff;  // writable control bits
  localparam logic [15:0]  CTRL_RST     = 16'h0000;
  localparam logic [15:0]  FLT_RST      = 16'h0001;  // faults armed after reset
  localparam logic [15:0]  OEN_RST      = 16'h0000;
  localparam logic [14:0]  PERIOD_RST   = 15'h0000;
  localparam int unsigned  CNT_MSB      = 14;        // count value bits 14..0
  localparam int unsigned  DIR_BIT      = 15;        // direction flag bit

  // counting modes
  localparam logic [1:0]   MODE_FREE    = 2'b00;
  localparam logic [1:0]   MODE_SINGLE  = 2'b01;
  localparam logic [1:0]   MODE_UPDN    = 2'b10;
  localparam logic [1:0]   MODE_UPDN_DB = 2'b11;

  // prescaler selects and terminal counts (division minus one)
  localparam logic [1:0]   PRE_SEL_1    = 2'b00;
  localparam logic [1:0]   PRE_SEL_4    = 2'b01;
  localparam logic [1:0]   PRE_SEL_16   = 2'b10;
  localparam logic [5:0]   PRE_LIM_1    = 6'h00;
  localparam logic [5:0]   PRE_LIM_4    = 6'h03;
  localparam logic [5:0]   PRE_LIM_16   = 6'h0f;
  localparam logic [5:0]   PRE_LIM_64   = 6'h3f;

  // interrupt status bits
  localparam int unsigned  INT_W        = 2;
  localparam int unsigned  INT_TB_EVT   = 0;  // postscaled time base event
  localparam int unsigned  INT_SINGLE   = 1;  // single-event run finished

  // unlock sequence states
  typedef enum logic [1:0] {LK_LOCKED, LK_HALF, LK_OPEN} mtb_lock_e;

endpackage : mtb_pkg
`default_nettype wire

// >>> inc/mtb_tick_if.sv
`default_nettype none
// ----------------------------------------------------------------------------
// prescaler hookup between the time base and its clock divider
// ----------------------------------------------------------------------------
interface mtb_tick_if;
  logic       run;   // divider counts while high, clears while low
  logic [1:0] sel;   // input_prescale_sel
  logic       tick;  // one-cycle pulse per divided input clock
  modport ctl (output run, output sel, input tick);
  modport pre (input run, input sel, output tick);
endinterface : mtb_tick_if
`default_nettype wire

// >>> design/mtb_prescaler.sv
`default_nettype none
// ----------------------------------------------------------------------------
// input clock prescaler: tick once every 1, 4, 16 or 64 clocks
// ----------------------------------------------------------------------------
module mtb_prescaler
  import mtb_pkg::*;
(
  input  wire logic clk_sys_i,  // system clock
  input  wire logic rst_n_i,    // synchronous reset, active low
  mtb_tick_if.pre   tk          // run, select and tick
);

  typedef struct packed {
    logic [5:0] cnt;   // clocks since last tick
    logic       tick;  // registered tick
  } mtb_pre_s;

  mtb_pre_s   st_r;  // state
  mtb_pre_s   st_nxt;
  logic [5:0] lim;   // terminal count for the selected division

  // division lookup and counting
  always_comb begin
    unique case (tk.sel)
      PRE_SEL_1:  lim = PRE_LIM_1;
      PRE_SEL_4:  lim = PRE_LIM_4;
      PRE_SEL_16: lim = PRE_LIM_16;
      default:    lim = PRE_LIM_64;
    endcase
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (!tk.run) begin
      // restart from zero so the first tick after start is a full period
      st_nxt.cnt = '0;
    end else if (st_r.cnt >= lim) begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 6'h01;
    end
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tk.tick = st_r.tick;

  a_pre_div4_gap: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (st_r.tick && tk.sel == PRE_SEL_4 && tk.run) |=> !st_r.tick [*3])
    else $error("prescale 1:4 ticked too soon");

endmodule : mtb_prescaler
`default_nettype wire

// >>> design/mtb_time_base.sv
// Added by the designer: the APB interface to the registers and the register addresses.
`default_nettype none
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
module mtb_time_base
  import mtb_pkg::*;
(
  input  wire logic        clk_sys_i,         // system clock, 10 MHz
  input  wire logic        rst_n_i,           // synchronous reset, active low
  input  wire logic        psel_i,            // apb select
  input  wire logic        penable_i,         // apb access phase
  input  wire logic        pwrite_i,          // apb direction
  input  wire logic [7:0]  paddr_i,           // apb byte address
  input  wire logic [31:0] pwdata_i,          // apb write data
  output logic      [31:0] prdata_o,          // apb read data
  output logic             pready_o,          // apb ready
  output logic             pslverr_o,         // apb error, unmapped address
  input  wire logic        cpu_idle_i,        // cpu in idle mode, same clock
  input  wire logic        fault_a_pin_i,     // fault pin a, asynchronous
  input  wire logic        fault_b_pin_i,     // fault pin b, asynchronous
  output logic      [15:0] fault_a_control_o, // fault a control value
  output logic      [15:0] fault_b_control_o, // fault b control value
  output logic      [15:0] output_enable_control_o, // output enables
  output logic      [15:0] time_base_count_o, // direction flag and count
  output logic             tb_event_o,        // postscaled event pulse
  output logic             irq_o              // level interrupt
);

  import mtb_pkg::*;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    mtb_ctrl_s          ctrl;     // time_base_control
    logic               dir;      // count_direction_flag, 1 = down
    logic [CNT_MSB:0]   count;    // count_value
    logic [CNT_MSB:0]   period;   // period compare
    logic [15:0]        flt_a;    // fault_a_control
    logic [15:0]        flt_b;    // fault_b_control
    logic [15:0]        oen;      // output_enable_control
    mtb_lock_e          lock;     // unlock sequence progress
    logic [INT_W-1:0]   stat;     // sticky interrupt status
    logic [INT_W-1:0]   mask;     // interrupt mask
    logic [3:0]         post;     // postscaler event count
    logic               evt;      // postscaled event pulse
    logic               irq;      // registered interrupt level
    logic [31:0]        prdata;   // read data captured in setup
    logic               perr;     // decode error captured in setup
    logic [1:0]         sync_a;   // fault a synchroniser
    logic [1:0]         sync_b;   // fault b synchroniser
  } mtb_state_s;

  localparam mtb_state_s ST_RST = '{ctrl: CTRL_RST, period: PERIOD_RST,
                                    flt_a: FLT_RST, flt_b: FLT_RST,
                                    oen: OEN_RST, lock: LK_LOCKED, default: '0};

  mtb_state_s  st_r;      // registered state
  mtb_state_s  st_nxt;    // next state
  mtb_tick_if  tk ();     // prescaler hookup

  logic        setup;     // apb setup cycle
  logic        acc;       // apb access completes this edge
  logic        wr;        // completing write
  logic        rd;        // completing read
  logic        run;       // counter allowed to advance
  logic        top;       // count at period
  logic        bot;       // count at zero
  logic        hit;       // raw time base event this cycle
  logic        prot_ok;   // protected write allowed
  logic        dec_ok;    // address decodes to a register
  logic [15:0] rd_val;    // read mux result
  logic [15:0] wd;        // low half of write data

  // --------------------------------------------------------------------------
  // bus phase decode; zero wait states, so every access phase completes
  // --------------------------------------------------------------------------
  assign setup    = psel_i && !penable_i;
  assign acc      = psel_i && penable_i;
  assign wr       = acc && pwrite_i;
  assign rd       = acc && !pwrite_i;
  assign wd       = pwdata_i[15:0];
  assign prot_ok  = (st_r.lock == LK_OPEN);
  assign pready_o = 1'b1;
  assign pslverr_o = acc && st_r.perr;

  // halt in idle gates the enable; single mode clears the enable itself
  assign run = st_r.ctrl.time_base_on
            && !(st_r.ctrl.halt_in_idle && cpu_idle_i);
  assign top = (st_r.count == st_r.period);
  assign bot = (st_r.count == '0);

  assign tk.run = run;
  assign tk.sel = st_r.ctrl.input_prescale_sel;

  mtb_prescaler u_pre (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .tk        (tk)
  );

  // --------------------------------------------------------------------------
  // read mux, sampled in the setup cycle so read data leaves a flip-flop
  // --------------------------------------------------------------------------
  always_comb begin
    rd_val = '0;
    dec_ok = 1'b1;
    unique case (paddr_i)
      OFS_CTRL:     rd_val = st_r.ctrl & CTRL_WMASK;
      OFS_COUNT:    rd_val = {st_r.dir, st_r.count};
      OFS_PERIOD:   rd_val = {1'b0, st_r.period};
      OFS_KEY:      rd_val = {14'h0000, st_r.sync_b[1], st_r.sync_a[1]};
      OFS_FLT_A:    rd_val = st_r.flt_a;
      OFS_FLT_B:    rd_val = st_r.flt_b;
      OFS_OEN:      rd_val = st_r.oen;
      OFS_INT_STAT: rd_val = {14'h0000, st_r.stat};
      OFS_INT_MASK: rd_val = {14'h0000, st_r.mask};
      default:      dec_ok = 1'b0;                           // unmapped
    endcase
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_nxt     = st_r;
    st_nxt.evt = 1'b0;
    hit        = 1'b0;

    // fault pins: first stage feeds only the second
    st_nxt.sync_a = {st_r.sync_a[0], fault_a_pin_i};
    st_nxt.sync_b = {st_r.sync_b[0], fault_b_pin_i};

    // counting on each prescaled tick
    if (run && tk.tick) begin
      unique case (st_r.ctrl.count_mode_sel)
        MODE_FREE, MODE_SINGLE: begin
          st_nxt.dir = 1'b0;
          if (top) begin
            st_nxt.count = '0;
            hit          = 1'b1;
            if (st_r.ctrl.count_mode_sel == MODE_SINGLE) begin
              st_nxt.ctrl.time_base_on = 1'b0;
              st_nxt.stat[INT_SINGLE]  = 1'b1;
            end
          end else begin
            st_nxt.count = st_r.count + 15'h0001;
          end
        end
        MODE_UPDN, MODE_UPDN_DB: begin
          // the turn costs one tick at each end, which keeps a zero period safe
          if (!st_r.dir) begin
            if (top) begin
              st_nxt.dir = 1'b1;
              hit = (st_r.ctrl.count_mode_sel == MODE_UPDN_DB);
            end else begin
              st_nxt.count = st_r.count + 15'h0001;
            end
          end else begin
            if (bot) begin
              st_nxt.dir = 1'b0;
              hit        = 1'b1;
            end else begin
              st_nxt.count = st_r.count - 15'h0001;
            end
          end
        end
      endcase
    end

    // output postscaler
    if (hit) begin
      if (st_r.post >= st_r.ctrl.output_postscale_sel) begin
        st_nxt.post = '0;
        st_nxt.evt  = 1'b1;
      end else begin
        st_nxt.post = st_r.post + 4'h1;
      end
    end

    // bus setup: capture read data and decode result
    if (setup) begin
      st_nxt.prdata = {16'h0000, rd_val};
      st_nxt.perr   = !dec_ok;
    end

    // bus writes; software wins over the counter in the same cycle
    if (wr) begin
      unique case (paddr_i)
        OFS_CTRL:     st_nxt.ctrl   = wd & CTRL_WMASK;
        OFS_COUNT:    st_nxt.count  = wd[CNT_MSB:0];
        OFS_PERIOD:   st_nxt.period = wd[CNT_MSB:0];
        OFS_INT_MASK: st_nxt.mask   = wd[INT_W-1:0];
        OFS_FLT_A:    if (prot_ok) st_nxt.flt_a = wd;
        OFS_FLT_B:    if (prot_ok) st_nxt.flt_b = wd;
        OFS_OEN:      if (prot_ok) st_nxt.oen   = wd;
        default:      ;                                      // key or read-only
      endcase
    end

    // any completed access moves the unlock sequence
    if (acc) begin
      unique case (st_r.lock)
        LK_LOCKED: st_nxt.lock = (wr && paddr_i == OFS_KEY && wd == KEY_FIRST)
                                 ? LK_HALF : LK_LOCKED;
        LK_HALF: begin
          if (wr && paddr_i == OFS_KEY && wd == KEY_SECOND) begin
            st_nxt.lock = LK_OPEN;
          end else if (wr && paddr_i == OFS_KEY && wd == KEY_FIRST) begin
            st_nxt.lock = LK_HALF;
          end else begin
            st_nxt.lock = LK_LOCKED;
          end
        end
        LK_OPEN: st_nxt.lock = (wr && paddr_i == OFS_KEY && wd == KEY_FIRST)
                               ? LK_HALF : LK_LOCKED;
      endcase
    end

    // read of status clears only the bits that were returned
    if (rd && paddr_i == OFS_INT_STAT) begin
      st_nxt.stat = st_r.stat & ~st_r.prdata[INT_W-1:0];
    end
    // a new event in the clearing cycle is kept: set after clear
    if (st_nxt.evt) begin
      st_nxt.stat[INT_TB_EVT] = 1'b1;
    end
    if (run && tk.tick && top && !st_r.dir
        && st_r.ctrl.count_mode_sel == MODE_SINGLE) begin
      st_nxt.stat[INT_SINGLE] = 1'b1;
    end
    st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs, all from flip-flops
  assign prdata_o                = st_r.prdata;
  assign fault_a_control_o       = st_r.flt_a;
  assign fault_b_control_o       = st_r.flt_b;
  assign output_enable_control_o = st_r.oen;
  assign time_base_count_o       = {st_r.dir, st_r.count};
  assign tb_event_o              = st_r.evt;
  assign irq_o                   = st_r.irq;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_count_held_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (!st_r.ctrl.time_base_on && !(wr && paddr_i == OFS_COUNT))
    |=> $stable(st_r.count) && $stable(st_r.dir))
    else $error("count moved while disabled");

  a_idle_halts_count: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (st_r.ctrl.halt_in_idle && cpu_idle_i && !(wr && paddr_i == OFS_COUNT))
    |=> $stable(st_r.count))
    else $error("count moved in idle with halt set");

  a_post_ratio: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (hit && st_r.post == st_r.ctrl.output_postscale_sel) |=> st_r.evt && st_r.post == '0)
    else $error("postscaler missed its terminal event");

  a_free_wrap_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (run && tk.tick && top && st_r.ctrl.count_mode_sel == MODE_FREE && !wr)
    |=> st_r.count == '0 && !st_r.dir)
    else $error("free-running count did not wrap");

  a_single_stops: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (run && tk.tick && top && st_r.ctrl.count_mode_sel == MODE_SINGLE && !wr)
    |=> !st_r.ctrl.time_base_on ##1 !st_r.ctrl.time_base_on || $past(wr))
    else $error("single event run did not stop");

  a_updown_turn: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (run && tk.tick && top && !st_r.dir && st_r.ctrl.count_mode_sel[1])
    |=> st_r.dir)
    else $error("up/down count did not turn at period");

  a_dir_readback: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (setup && !pwrite_i && paddr_i == OFS_COUNT)
    |=> st_r.prdata[DIR_BIT] == $past(st_r.dir))
    else $error("direction flag read back wrong");

  a_lock_blocks_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (wr && paddr_i == OFS_FLT_A && st_r.lock != LK_OPEN) |=> $stable(st_r.flt_a))
    else $error("locked fault control was written");

  a_unlock_one_shot: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (acc && st_r.lock == LK_OPEN) |=> st_r.lock != LK_OPEN)
    else $error("unlock survived past one access");

endmodule : mtb_time_base
`default_nettype wire

// >>> test/mtb_time_base_tb.sv
`default_nettype none
module mtb_time_base_tb
  import mtb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------------------
  logic        clk_sys_i, rst_n_i, psel_i, penable_i, pwrite_i;  // clock, reset, apb strobes
  logic        cpu_idle_i, fault_a_pin_i, fault_b_pin_i;         // side inputs
  logic [7:0]  paddr_i;                                          // apb byte address
  logic [31:0] pwdata_i, prdata_o, q;                            // write, read, last read
  logic [15:0] fa_o, fb_o, oen_o, cnt_o;                         // register mirrors
  logic        pready_o, pslverr_o, tb_event_o, irq_o, e;        // status outputs
  int          failures, comparisons, n;                         // tallies, measured figure

  mtb_time_base i_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .cpu_idle_i(cpu_idle_i),
    .fault_a_pin_i(fault_a_pin_i), .fault_b_pin_i(fault_b_pin_i),
    .fault_a_control_o(fa_o), .fault_b_control_o(fb_o), .output_enable_control_o(oen_o),
    .time_base_count_o(cnt_o), .tb_event_o(tb_event_o), .irq_o(irq_o));

  // clock at 100 ns
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // one apb transfer; ends on a falling edge so registered outputs have settled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge clk_sys_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    // no fixed latency assumed: hold until ready is seen
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(negedge clk_sys_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask

  // both keys back to back, nothing in between
  task automatic unlock();
    wr(OFS_KEY, {16'h0, KEY_FIRST});
    wr(OFS_KEY, {16'h0, KEY_SECOND});
  endtask

  function automatic logic [15:0] ctl(logic on, logic hi, logic [3:0] ops, logic [1:0] pre,
                                      logic [1:0] md);
    return {on, 1'b0, hi, 5'h00, ops, pre, md};
  endfunction

  // clocks between two event pulses, bounded so a dead counter cannot hang us
  task automatic gap(output int g);
    int k;
    k = 0;
    g = 1;
    @(negedge clk_sys_i);
    while (tb_event_o !== 1'b1 && k < 5000) begin
      @(negedge clk_sys_i);
      k++;
    end
    @(negedge clk_sys_i);
    while (tb_event_o !== 1'b1 && g < 5000) begin
      @(negedge clk_sys_i);
      g++;
    end
  endtask

  // restart from zero, skip the first irregular gap, compare the second
  task automatic cfg_gap(input logic [15:0] c, input int exp);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_CTRL, {16'h0, c});
    gap(n);
    gap(n);
    chk(n, exp);
  endtask

  // cycles with the down flag set, out of sixteen
  task automatic count_dir(output int g);
    g = 0;
    repeat (16) begin
      @(negedge clk_sys_i);
      if (cnt_o[DIR_BIT] === 1'b1) g++;
    end
  endtask

  // does the count stand still for 21 clocks; a multiple of the 4-step
  // wrap at period 3 would bring a running count back to its start value
  task automatic still(input logic [15:0] c, input logic idle, input logic exp);
    logic [15:0] s;
    @(posedge clk_sys_i);
    cpu_idle_i <= idle;
    wr(OFS_CTRL, {16'h0, c});
    repeat (3) @(negedge clk_sys_i);
    s = cnt_o;
    repeat (21) @(negedge clk_sys_i);
    chk(cnt_o === s, exp);
  endtask

  task automatic done(input string t);
    $display("test %s finished", t);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under ten thousand clocks
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    failures++;
    wrap_up();
  end

  // ----------------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------------
  initial begin
    {rst_n_i, psel_i, penable_i, pwrite_i, cpu_idle_i, fault_a_pin_i, fault_b_pin_i} = '0;
    paddr_i  = 8'h00;
    pwdata_i = 32'h0;
    failures = 0;
    comparisons = 0;
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(negedge clk_sys_i);
    chk(fa_o, FLT_RST);
    chk(oen_o, OEN_RST);
    rd_chk(OFS_CTRL, CTRL_RST);
    rd_chk(OFS_COUNT, 32'h0);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk(e, 1'b1);
    chk(q, 32'h0);
    done("reset and map");
    // pins high before the faults are cleared, driven on a rising edge
    @(posedge clk_sys_i);
    fault_a_pin_i <= 1'b1;
    fault_b_pin_i <= 1'b1;
    wr(OFS_FLT_A, 32'h0);
    chk(fa_o, FLT_RST);
    unlock();
    wr(OFS_FLT_A, 32'h0);
    chk(fa_o, 16'h0000);
    wr(OFS_FLT_A, 32'h5);
    chk(fa_o, 16'h0000);
    unlock();
    wr(OFS_FLT_B, 32'h0);
    chk(fb_o, 16'h0000);
    // a stray access between the keys must keep the lock shut
    wr(OFS_KEY, {16'h0, KEY_FIRST});
    rd_chk(OFS_CTRL, 32'h0);
    wr(OFS_KEY, {16'h0, KEY_SECOND});
    wr(OFS_OEN, 32'h77);
    chk(oen_o, 16'h0000);
    unlock();
    wr(OFS_OEN, 32'h77);
    chk(oen_o, 16'h0077);
    apb(1'b0, OFS_KEY, 32'h0, q, e);
    chk(q[0], 1'b1);
    done("write protection");
    wr(OFS_COUNT, 32'h9234);
    rd_chk(OFS_COUNT, 32'h1234);
    done("count register");
    wr(OFS_PERIOD, 32'h3);
    for (int p = 0; p < 4; p++) cfg_gap(ctl(1, 0, 0, 2'(p), MODE_FREE), 4 << (2 * p));
    cfg_gap(ctl(1, 0, 4'h1, PRE_SEL_1, MODE_FREE), 8);
    count_dir(n);
    chk(n, 0);
    cfg_gap(ctl(1, 0, 4'hf, PRE_SEL_4, MODE_FREE), 256);
    cfg_gap(ctl(1, 0, 0, PRE_SEL_1, MODE_UPDN), 8);
    cfg_gap(ctl(1, 0, 0, PRE_SEL_1, MODE_UPDN_DB), 4);
    count_dir(n);
    chk(n, 8);
    done("rates and modes");
    still(ctl(0, 0, 0, PRE_SEL_1, MODE_FREE), 1'b0, 1'b1);
    still(ctl(1, 1, 0, PRE_SEL_1, MODE_FREE), 1'b1, 1'b1);
    still(ctl(1, 0, 0, PRE_SEL_1, MODE_FREE), 1'b1, 1'b0);
    still(ctl(1, 1, 0, PRE_SEL_1, MODE_FREE), 1'b0, 1'b0);
    done("run control");
    wr(OFS_INT_MASK, 32'h0);
    wr(OFS_CTRL, 32'h0);
    apb(1'b0, OFS_INT_STAT, 32'h0, q, e);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_CTRL, {16'h0, ctl(1, 0, 0, PRE_SEL_1, MODE_SINGLE)});
    repeat (30) @(negedge clk_sys_i);
    chk(irq_o, 1'b0);
    rd_chk(OFS_CTRL, {16'h0, ctl(0, 0, 0, PRE_SEL_1, MODE_SINGLE)});
    rd_chk(OFS_COUNT, 32'h0);
    wr(OFS_INT_MASK, 32'h3);
    @(negedge clk_sys_i);
    chk(irq_o, 1'b1);
    rd_chk(OFS_INT_STAT, 32'h3);
    @(negedge clk_sys_i);
    chk(irq_o, 1'b0);
    rd_chk(OFS_INT_STAT, 32'h0);
    done("single event and interrupt");
    wrap_up();
  end
endmodule // mtb_time_base_tb
`default_nettype wire
